// ==== rtl/cdr_defines.svh ====
// frame identifiers, command bytes, object indices and layout constants of the diagnostic link
`ifndef CDR_DEFINES_SVH
`define CDR_DEFINES_SVH
`define CDR_EMCY_BASE 11'h080
`define CDR_SDO_RX_BASE 11'h600
`define CDR_SDO_TX_BASE 11'h580
`define CDR_DLC_FULL 4'h8
`define CDR_CMD_UPLOAD_REQ 8'h40
`define CDR_CMD_UPLOAD_RSP 8'h42
`define CDR_CMD_ABORT 8'h80
`define CDR_IDX_STATUS 16'h3100
`define CDR_IDX_HISTORY 16'h1003
`define CDR_SUB_LAST_ERR 8'h01
`define CDR_SUB_POS_OFS 8'h03
`define CDR_POS_COUNT 8'h10
`define CDR_CODE_ALL_CLEAR 16'h0000
`define CDR_ABORT_NO_OBJECT 32'h06020000
`define CDR_ABORT_NO_SUB 32'h06090011
`define CDR_ABORT_BAD_CMD 32'h05040001
`define CDR_NODE_W 7
`define CDR_POS_W 4
`endif

// ==== rtl/cdr_pkg.sv ====
// types shared by both ends of the diagnostic link
package cdr_pkg;
	typedef logic [63:0] cdr_payload_t;
	typedef logic [10:0] cdr_id_t;
	typedef enum logic [1:0] {CDR_TX_IDLE, CDR_TX_EMCY, CDR_TX_SDO} cdr_dev_state_t;
	typedef enum logic {CDR_M_IDLE, CDR_M_WAIT} cdr_mst_state_t;
endpackage

// ==== rtl/cdr_link_if.sv ====
// frame-level link between the diagnostic responder and the bus master
`timescale 1ns/1ps
interface cdr_link_if;
	logic req_valid;
	logic [10:0] req_id;
	logic [3:0] req_dlc;
	logic [63:0] req_data;
	logic rsp_valid;
	logic rsp_ready;
	logic [10:0] rsp_id;
	logic [3:0] rsp_dlc;
	logic [63:0] rsp_data;
	modport dev (input req_valid, req_id, req_dlc, req_data, rsp_ready,
		output rsp_valid, rsp_id, rsp_dlc, rsp_data);
	modport mst (output req_valid, req_id, req_dlc, req_data, rsp_ready,
		input rsp_valid, rsp_id, rsp_dlc, rsp_data);
endinterface

// ==== rtl/cdr_device.sv ====
// gateway end: emergency frames and expedited uploads of module status and last error
// Summary of operation
// R1: emergency identifier is 80h plus node address
// R2: all frames carry eight data bytes
// R3: error code in bytes 0-1, low first
// R4: byte 2 carries current error register
// R5: byte 3 carries faulty module index
// R6: state bit 30 to byte 4 bit 6
// R7: status bit 8 to byte 6 bit 0
// R8: master requests on 600h plus node address
// R9: responses use 580h plus node address
// R10: master upload request command byte is 40h
// R11: answer command 42h, echo index and subindex
// R12: index low byte first, subindex in byte 3
// R13: status subindex minus three gives module position
// R14: status answer bits are active low
// R15: status answer bytes 4-7 in emergency order
// R16: history subindex 1 returns last error entry
// R17: last error keeps recorded state bit pattern
// R18: master zero-fills, waits for each response
// R19: ignore requests for other node addresses
`timescale 1ns/1ps
`include "cdr_defines.svh"
module cdr_device
	import cdr_pkg::*;
(
	input wire logic clock_i,
	input wire logic srst_i,
	cdr_link_if.dev link,
	input wire logic [6:0] node_addr_i,
	input wire logic emcy_req_i,
	input wire logic [15:0] emcy_code_i,
	input wire logic [7:0] err_reg_i,
	input wire logic [7:0] module_index_i,
	input wire logic [31:0] diag_i,
	input wire logic stat_we_i,
	input wire logic [3:0] stat_pos_i,
	input wire logic [31:0] stat_i,
	output logic emcy_pend_o,
	output logic sdo_busy_o,
	output logic [31:0] last_err_o
);
	cdr_dev_state_t state_reg;
	cdr_dev_state_t state_next;
	logic emcy_pend_reg;
	logic emcy_pend_next;
	logic [63:0] emcy_frame_reg;
	logic sdo_pend_reg;
	logic [7:0] req_cmd_reg;
	logic [15:0] req_index_reg;
	logic [7:0] req_sub_reg;
	logic [31:0] last_err_reg;
	logic [31:0] stat_mem [0:15];
	logic rsp_valid_reg;
	logic [10:0] rsp_id_reg;
	logic [63:0] rsp_data_reg;

	// node-relative identifier, cut to the 11-bit field
	function automatic cdr_id_t node_id(input cdr_id_t base, input logic [6:0] node);
		node_id = base + {4'h0, node};
	endfunction

	// diagnostic word to bytes 4..7, bit 31 highest in byte 4
	function automatic logic [31:0] diag_bytes(input logic [31:0] d);
		diag_bytes = {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction

	wire req_for_us = link.req_valid && (link.req_id == node_id(`CDR_SDO_RX_BASE, node_addr_i)); // R8 R19
	wire req_full = link.req_dlc == `CDR_DLC_FULL; // R2
	wire req_take = req_for_us && req_full && !sdo_pend_reg;
	wire tx_done = rsp_valid_reg && link.rsp_ready;

	// module position decode
	wire [7:0] pos_raw = req_sub_reg - `CDR_SUB_POS_OFS; // R13
	wire pos_ok = (req_sub_reg >= `CDR_SUB_POS_OFS) && (pos_raw < `CDR_POS_COUNT);
	wire [3:0] pos = pos_raw[3:0];
	wire [31:0] stat_word = stat_mem[pos];

	wire is_upload = req_cmd_reg == `CDR_CMD_UPLOAD_REQ;
	wire is_status = req_index_reg == `CDR_IDX_STATUS;
	wire is_history = req_index_reg == `CDR_IDX_HISTORY;
	wire hist_sub_ok = req_sub_reg == `CDR_SUB_LAST_ERR;

	// abort selection; unknown command outranks unknown object
	wire [31:0] abort_code = !is_upload ? `CDR_ABORT_BAD_CMD :
		(!is_status && !is_history) ? `CDR_ABORT_NO_OBJECT : `CDR_ABORT_NO_SUB;
	wire answer_ok = is_upload && ((is_status && pos_ok) || (is_history && hist_sub_ok));

	wire [31:0] status_payload = diag_bytes(~stat_word); // R14 R15
	wire [31:0] history_payload = diag_bytes(last_err_reg); // R16 R17
	wire [31:0] ok_payload = is_status ? status_payload : history_payload;
	wire [31:0] rsp_payload = answer_ok ? ok_payload :
		{abort_code[31:24], abort_code[23:16], abort_code[15:8], abort_code[7:0]};
	wire [7:0] rsp_cmd = answer_ok ? `CDR_CMD_UPLOAD_RSP : `CDR_CMD_ABORT; // R11
	// index low byte first, subindex echoed
	wire [63:0] sdo_frame = {rsp_payload, req_sub_reg, req_index_reg[15:8],
		req_index_reg[7:0], rsp_cmd}; // R11 R12

	// emergency frame assembled when the event arrives
	wire [63:0] emcy_frame = {diag_bytes(diag_i), module_index_i, err_reg_i,
		emcy_code_i[15:8], emcy_code_i[7:0]}; // R3 R4 R5 R6 R7
	wire history_write = emcy_req_i && (emcy_code_i != `CDR_CODE_ALL_CLEAR);

	// a new event in the cycle its predecessor leaves keeps the flag set
	assign emcy_pend_next = emcy_req_i || (emcy_pend_reg && !(state_reg == CDR_TX_EMCY && tx_done));

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			CDR_TX_IDLE:
			begin
				if (emcy_pend_reg)
					state_next = CDR_TX_EMCY;
				else if (sdo_pend_reg)
					state_next = CDR_TX_SDO;
			end
			CDR_TX_EMCY, CDR_TX_SDO:
			begin
				if (tx_done)
					state_next = CDR_TX_IDLE;
			end
			// the fourth code of the state word is never entered; recover to idle
			default:
				state_next = CDR_TX_IDLE;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			state_reg <= CDR_TX_IDLE;
			emcy_pend_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			emcy_pend_reg <= emcy_pend_next;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
			emcy_frame_reg <= '0;
		else if (emcy_req_i)
			emcy_frame_reg <= emcy_frame;
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
			last_err_reg <= '0;
		else if (history_write)
			last_err_reg <= diag_i; // R17
	end

	// status table; zero reset means every bit reads back as error-free-ones inverted
	generate
		for (genvar g = 0; g < 16; g++)
		begin : g_stat
			always_ff @(posedge clock_i)
			begin
				if (srst_i)
					stat_mem[g] <= '0;
				else if (stat_we_i && stat_pos_i == 4'(g))
					stat_mem[g] <= stat_i;
			end
		end
	endgenerate

	// one request held at a time; extra requests while answering are dropped
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
			sdo_pend_reg <= 1'b0;
		else if (req_take)
			sdo_pend_reg <= 1'b1;
		else if (state_reg == CDR_TX_SDO && tx_done)
			sdo_pend_reg <= 1'b0;
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			req_cmd_reg <= '0;
			req_index_reg <= '0;
			req_sub_reg <= '0;
		end
		else if (req_take)
		begin
			req_cmd_reg <= link.req_data[7:0];
			req_index_reg <= {link.req_data[23:16], link.req_data[15:8]}; // R12
			req_sub_reg <= link.req_data[31:24];
		end
	end

	// transmit holding register, valid until the master takes it
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			rsp_valid_reg <= 1'b0;
			rsp_id_reg <= '0;
			rsp_data_reg <= '0;
		end
		else if (state_reg == CDR_TX_IDLE && emcy_pend_reg)
		begin
			rsp_valid_reg <= 1'b1;
			rsp_id_reg <= node_id(`CDR_EMCY_BASE, node_addr_i); // R1
			rsp_data_reg <= emcy_frame_reg;
		end
		else if (state_reg == CDR_TX_IDLE && sdo_pend_reg)
		begin
			rsp_valid_reg <= 1'b1;
			rsp_id_reg <= node_id(`CDR_SDO_TX_BASE, node_addr_i); // R9
			rsp_data_reg <= sdo_frame;
		end
		else if (tx_done)
			rsp_valid_reg <= 1'b0;
	end

	assign link.rsp_valid = rsp_valid_reg;
	assign link.rsp_id = rsp_id_reg;
	assign link.rsp_dlc = `CDR_DLC_FULL; // R2
	assign link.rsp_data = rsp_data_reg;
	assign emcy_pend_o = emcy_pend_reg;
	assign sdo_busy_o = sdo_pend_reg;
	assign last_err_o = last_err_reg;
endmodule // cdr_device

// ==== rtl/cdr_master.sv ====
// bus-master end: issues expedited uploads and receives emergencies
`timescale 1ns/1ps
`include "cdr_defines.svh"
module cdr_master
	import cdr_pkg::*;
(
	input wire logic clock_i,
	input wire logic srst_i,
	cdr_link_if.mst link,
	input wire logic [6:0] node_addr_i,
	input wire logic up_req_i,
	input wire logic [15:0] up_index_i,
	input wire logic [7:0] up_sub_i,
	output logic up_busy_o,
	output logic up_done_o,
	output logic up_abort_o,
	output logic [31:0] up_data_o,
	output logic emcy_o,
	output logic [15:0] emcy_code_o,
	output logic [7:0] emcy_err_reg_o,
	output logic [7:0] emcy_module_o,
	output logic [31:0] emcy_diag_o
);
	cdr_mst_state_t state_reg;
	logic req_valid_reg;
	logic [10:0] req_id_reg;
	logic [63:0] req_data_reg;
	logic ready_reg;
	logic done_reg;
	logic abort_reg;
	logic [31:0] data_reg;
	logic emcy_reg;
	logic [63:0] emcy_data_reg;

	wire [63:0] d = link.rsp_data;
	wire rx = link.rsp_valid && ready_reg && (link.rsp_dlc == `CDR_DLC_FULL); // R2
	wire rx_emcy = rx && (link.rsp_id == `CDR_EMCY_BASE + {4'h0, node_addr_i});
	wire rx_sdo = rx && (link.rsp_id == `CDR_SDO_TX_BASE + {4'h0, node_addr_i});
	wire start = up_req_i && state_reg == CDR_M_IDLE;
	wire finish = rx_sdo && state_reg == CDR_M_WAIT;
	// unused bytes zero, index low first
	wire [63:0] req_frame = {32'h0000_0000, up_sub_i, up_index_i[15:8], up_index_i[7:0],
		`CDR_CMD_UPLOAD_REQ}; // R10 R12 R18

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			state_reg <= CDR_M_IDLE;
			req_valid_reg <= 1'b0;
			req_id_reg <= '0;
			req_data_reg <= '0;
			ready_reg <= 1'b0;
		end
		else
		begin
			ready_reg <= 1'b1;
			req_valid_reg <= start;
			if (start)
			begin
				state_reg <= CDR_M_WAIT; // R18
				req_id_reg <= `CDR_SDO_RX_BASE + {4'h0, node_addr_i}; // R8
				req_data_reg <= req_frame;
			end
			else if (finish)
				state_reg <= CDR_M_IDLE;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			done_reg <= 1'b0;
			abort_reg <= 1'b0;
			data_reg <= '0;
			emcy_reg <= 1'b0;
			emcy_data_reg <= '0;
		end
		else
		begin
			done_reg <= finish;
			emcy_reg <= rx_emcy;
			if (finish)
			begin
				abort_reg <= d[7:0] == `CDR_CMD_ABORT;
				data_reg <= {d[39:32], d[47:40], d[55:48], d[63:56]};
			end
			if (rx_emcy)
				emcy_data_reg <= d;
		end
	end

	assign link.req_valid = req_valid_reg;
	assign link.req_id = req_id_reg;
	assign link.req_dlc = `CDR_DLC_FULL;
	assign link.req_data = req_data_reg;
	assign link.rsp_ready = ready_reg;
	assign up_busy_o = state_reg == CDR_M_WAIT;
	assign up_done_o = done_reg;
	assign up_abort_o = abort_reg;
	assign up_data_o = data_reg;
	assign emcy_o = emcy_reg;
	assign emcy_code_o = {emcy_data_reg[15:8], emcy_data_reg[7:0]};
	assign emcy_err_reg_o = emcy_data_reg[23:16];
	assign emcy_module_o = emcy_data_reg[31:24];
	assign emcy_diag_o = {emcy_data_reg[39:32], emcy_data_reg[47:40], emcy_data_reg[55:48],
		emcy_data_reg[63:56]};
endmodule // cdr_master

// ==== tb/cdr_link_chk.sv ====
// checker for the diagnostic link: identifiers, lengths, command bytes
`timescale 1ns/1ps
`include "cdr_defines.svh"
module cdr_link_chk #(
	parameter logic [6:0] NODE = 7'h0c
) (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic req_valid,
	input wire logic [10:0] req_id,
	input wire logic [3:0] req_dlc,
	input wire logic [63:0] req_data,
	input wire logic rsp_valid,
	input wire logic rsp_ready,
	input wire logic [10:0] rsp_id,
	input wire logic [3:0] rsp_dlc,
	input wire logic [63:0] rsp_data
);
	wire logic sdo = rsp_valid && rsp_id == `CDR_SDO_TX_BASE + NODE;
	wire logic ok = rsp_data[7:0] == `CDR_CMD_UPLOAD_RSP;
	logic [23:0] echo_reg;
	// one request outstanding, so the last one taken is the one answered
	always_ff @(posedge clock_i)
		if (srst_i)
			echo_reg <= '0;
		else if (req_valid)
			echo_reg <= req_data[31:8];
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (srst_i);
	rsp_len_a: assert property (rsp_valid |-> rsp_dlc == `CDR_DLC_FULL)
		else $error("bad rsp length");
	req_len_a: assert property (req_valid |-> req_dlc == `CDR_DLC_FULL)
		else $error("bad req length");
	rsp_id_a: assert property (rsp_valid |-> sdo || rsp_id == `CDR_EMCY_BASE + NODE)
		else $error("bad rsp id");
	sdo_cmd_a: assert property (sdo |-> ok || rsp_data[7:0] == `CDR_CMD_ABORT)
		else $error("bad rsp command");
	sdo_echo_a: assert property (sdo && ok |-> rsp_data[31:8] == echo_reg)
		else $error("index not echoed");
	req_id_a: assert property (req_valid |-> req_id == `CDR_SDO_RX_BASE + NODE)
		else $error("bad req id");
	req_cmd_a: assert property (req_valid |-> req_data[7:0] == `CDR_CMD_UPLOAD_REQ
		&& req_data[63:32] == '0) else $error("bad req bytes");
	req_one_a: assert property (req_valid |=> !req_valid [*2])
		else $error("requests too close");
	sdo_ans_a: assert property (req_valid |-> ##[2:40] sdo)
		else $error("no answer");
	rsp_drop_a: assert property (rsp_valid && rsp_ready |=> !rsp_valid)
		else $error("frame held after handshake");
endmodule // cdr_link_chk

// ==== tb/tb_top.sv ====
// bench: both link ends, plus a spare responder fed faulty frames
`timescale 1ns/1ps
`include "cdr_defines.svh"
module tb_top;
	import cdr_pkg::*;
	localparam logic [6:0] NODE = 7'h0c;
	localparam logic [10:0] RX_ID = `CDR_SDO_RX_BASE + NODE;
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	logic er = 1'b0, we = 1'b0, ur = 1'b0, seen;
	logic [15:0] code = '0, idx = '0, ecode;
	logic [7:0] ereg = '0, mi = '0, sub = '0, ee, emod;
	logic [31:0] diag = '0, stat = '0, last = '0, ud, ediag, lerr;
	logic [3:0] pos = '0;
	logic [31:0] tbl [16];
	logic [74:0] frm, far;
	logic busy, done, ab, em, pend, sbusy;
	int n_fail = 0, check_count = 0, cycles = 0;
	cdr_link_if i_cdr_link_if ();
	cdr_link_if i_cdr_link_if_2 ();
	cdr_device i_cdr_device (.clock_i, .srst_i, .link(i_cdr_link_if.dev), .node_addr_i(NODE),
		.emcy_req_i(er), .emcy_code_i(code), .err_reg_i(ereg), .module_index_i(mi), .diag_i(diag),
		.stat_we_i(we), .stat_pos_i(pos), .stat_i(stat), .emcy_pend_o(pend), .sdo_busy_o(sbusy),
		.last_err_o(lerr));
	cdr_device i_cdr_device_2 (.clock_i, .srst_i, .link(i_cdr_link_if_2.dev), .node_addr_i(NODE),
		.emcy_req_i(er), .emcy_code_i(code), .err_reg_i(ereg), .module_index_i(mi), .diag_i(diag),
		.stat_we_i(we), .stat_pos_i(pos), .stat_i(stat), .emcy_pend_o(), .sdo_busy_o(),
		.last_err_o());
	cdr_master i_cdr_master (.clock_i, .srst_i, .link(i_cdr_link_if.mst), .node_addr_i(NODE),
		.up_req_i(ur), .up_index_i(idx), .up_sub_i(sub), .up_busy_o(busy), .up_done_o(done),
		.up_abort_o(ab), .up_data_o(ud), .emcy_o(em), .emcy_code_o(ecode), .emcy_err_reg_o(ee),
		.emcy_module_o(emod), .emcy_diag_o(ediag));
	cdr_link_chk #(.NODE(NODE)) i_cdr_link_chk (.clock_i, .srst_i,
		.req_valid(i_cdr_link_if.req_valid), .req_id(i_cdr_link_if.req_id),
		.req_dlc(i_cdr_link_if.req_dlc), .req_data(i_cdr_link_if.req_data),
		.rsp_valid(i_cdr_link_if.rsp_valid), .rsp_ready(i_cdr_link_if.rsp_ready),
		.rsp_id(i_cdr_link_if.rsp_id), .rsp_dlc(i_cdr_link_if.rsp_dlc),
		.rsp_data(i_cdr_link_if.rsp_data));
	initial
		forever #5 clock_i = ~clock_i;
	always @(posedge clock_i)
	begin
		cycles++;
		if (i_cdr_link_if.rsp_valid && i_cdr_link_if.rsp_ready)
			frm <= {i_cdr_link_if.rsp_id, i_cdr_link_if.rsp_data};
		if (cycles == 5000)
		begin
			n_fail++;
			finish_test();
		end
	end
	function automatic logic [31:0] sw(input logic [31:0] v);
		return {v[7:0], v[15:8], v[23:16], v[31:24]};
	endfunction
	task automatic chk(input string what, input logic [79:0] got, input logic [79:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick();
		@(posedge clock_i);
		#1;
	endtask
	task automatic await(input bit on_em);
		int n;
		n = 0;
		while ((on_em ? em : done) !== 1'b1 && n < 50)
		begin
			tick();
			n++;
		end
		chk("handshake", on_em ? em : done, 1'b1);
	endtask
	task automatic emit(input logic [15:0] c, input logic [7:0] e, m, input logic [31:0] d);
		code = c;
		ereg = e;
		mi = m;
		diag = d;
		er = 1'b1;
		tick();
		er = 1'b0;
		chk("emcy_pend", pend, 1'b1);
		await(1'b1);
		chk("emcy_wire", frm, {`CDR_EMCY_BASE + NODE, sw(d), m, e, c});
		chk("emcy_out", {ediag, emod, ee, ecode}, {d, m, e, c});
		if (c !== `CDR_CODE_ALL_CLEAR)
			last = d;
	endtask
	task automatic upload(input logic [15:0] x, input logic [7:0] s, input logic [31:0] w, a);
		idx = x;
		sub = s;
		ur = 1'b1;
		tick();
		ur = 1'b0;
		chk("up_busy", busy, 1'b1);
		await(1'b0);
		chk("sdo_wire", {frm[74:32], frm[7:0]}, {`CDR_SDO_TX_BASE + NODE, w,
			a[0] ? `CDR_CMD_ABORT : `CDR_CMD_UPLOAD_RSP});
		chk("up_out", {ab, ud}, {a[0], sw(w)});
	endtask
	task automatic far_req(input logic [10:0] id, input logic [3:0] dl, input logic [7:0] cmd);
		i_cdr_link_if_2.req_id = id;
		i_cdr_link_if_2.req_dlc = dl;
		i_cdr_link_if_2.req_data = {32'h0, 8'h04, `CDR_IDX_STATUS, cmd};
		i_cdr_link_if_2.req_valid = 1'b1;
		tick();
		i_cdr_link_if_2.req_valid = 1'b0;
		seen = 1'b0;
		repeat (10)
		begin
			if (i_cdr_link_if_2.rsp_valid === 1'b1)
			begin
				seen = 1'b1;
				far = {i_cdr_link_if_2.rsp_id, i_cdr_link_if_2.rsp_data};
			end
			tick();
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		foreach (tbl[i])
			tbl[i] = '0;
		i_cdr_link_if_2.req_valid = 1'b0;
		i_cdr_link_if_2.req_id = '0;
		i_cdr_link_if_2.req_dlc = '0;
		i_cdr_link_if_2.req_data = '0;
		i_cdr_link_if_2.rsp_ready = 1'b0;
		void'($urandom(16));
		repeat (10) @(posedge clock_i);
		#1;
		srst_i = 1'b0;
		// spare end must drain its own emergencies or its answers would queue behind them
		i_cdr_link_if_2.rsp_ready = 1'b1;
		tick();
		emit(16'hff03, 8'h01, 8'h03, 32'h40000000);
		emit(16'hff03, 8'h01, 8'h0b, 32'h00000100);
		repeat (6)
			emit(16'($urandom), 8'($urandom), 8'($urandom), $urandom);
		emit(`CDR_CODE_ALL_CLEAR, 8'h00, 8'h00, 32'h5a5a5a5a);
		$display("emcy test done");
		upload(`CDR_IDX_HISTORY, `CDR_SUB_LAST_ERR, sw(last), 1'b0);
		chk("last_err", lerr, last);
		for (int i = 0; i < 6; i++)
		begin
			pos = (i == 0) ? 4'h1 : 4'($urandom);
			stat = (i == 0) ? 32'h40000104 : $urandom;
			tbl[pos] = stat;
			we = 1'b1;
			tick();
		end
		we = 1'b0;
		for (int i = 0; i < 16; i++)
			upload(`CDR_IDX_STATUS, 8'(i + 3), sw(~tbl[i]), 1'b0);
		$display("status test done");
		upload(`CDR_IDX_STATUS, 8'h02, `CDR_ABORT_NO_SUB, 1'b1);
		upload(`CDR_IDX_STATUS, 8'h13, `CDR_ABORT_NO_SUB, 1'b1);
		upload(`CDR_IDX_HISTORY, 8'h02, `CDR_ABORT_NO_SUB, 1'b1);
		upload(16'h2000, 8'h00, `CDR_ABORT_NO_OBJECT, 1'b1);
		$display("abort test done");
		// emergency and upload in one cycle: the emergency must leave first
		code = 16'hff01;
		ereg = 8'h81;
		mi = 8'h02;
		diag = 32'h00000004;
		idx = `CDR_IDX_HISTORY;
		sub = `CDR_SUB_LAST_ERR;
		er = 1'b1;
		ur = 1'b1;
		tick();
		er = 1'b0;
		ur = 1'b0;
		last = diag;
		await(1'b1);
		chk("race_emcy", frm, {`CDR_EMCY_BASE + NODE, sw(diag), mi, ereg, code});
		chk("race_busy", busy, 1'b1);
		await(1'b0);
		chk("race_sdo", {ab, ud}, {1'b0, last});
		$display("race test done");
		far_req(RX_ID + 11'h001, `CDR_DLC_FULL, `CDR_CMD_UPLOAD_REQ);
		chk("far_other_id", seen, 1'b0);
		far_req(RX_ID, 4'h7, `CDR_CMD_UPLOAD_REQ);
		chk("far_short", seen, 1'b0);
		far_req(RX_ID, `CDR_DLC_FULL, 8'h23);
		chk("far_bad_cmd", {seen, far[63:32], far[7:0]}, {1'b1, `CDR_ABORT_BAD_CMD, 8'h80});
		far_req(RX_ID, `CDR_DLC_FULL, `CDR_CMD_UPLOAD_REQ);
		chk("far_status", {seen, far}, {1'b1, `CDR_SDO_TX_BASE + NODE, sw(~tbl[1]),
			8'h04, `CDR_IDX_STATUS, `CDR_CMD_UPLOAD_RSP});
		$display("far test done");
		chk("idle", {pend, sbusy, busy}, 3'b000);
		finish_test();
	end
endmodule // tb_top
